// [hdl/flash_port_pkg.sv]
package flash_port_pkg;

  // ----------------------------------------------------------------
  // Opcodes
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_READ     = 8'h03;
  localparam logic [7:0] OP_FAST     = 8'h0B;
  localparam logic [7:0] OP_DUAL_OUT = 8'h3B;
  localparam logic [7:0] OP_DUAL_IO  = 8'hBB;
  localparam logic [7:0] OP_QUAD_OUT = 8'h6B;
  localparam logic [7:0] OP_QUAD_IO  = 8'hEB;
  localparam logic [7:0] OP_WORD_QIO = 8'hE7;
  localparam logic [7:0] OP_OCTW_QIO = 8'hE3;
  localparam logic [7:0] OP_STAT1    = 8'h05;
  localparam logic [7:0] OP_STAT2    = 8'h35;
  localparam logic [7:0] OP_STAT3    = 8'h15;
  localparam logic [7:0] OP_ENTER_4L = 8'h38;
  localparam logic [7:0] OP_EXIT_4L  = 8'hFF;
  localparam logic [7:0] OP_EN_RESET = 8'h66;
  localparam logic [7:0] OP_RESET    = 8'h99;

  // ----------------------------------------------------------------
  // Counts and timing
  // ----------------------------------------------------------------
  localparam logic [4:0] OPC_BITS       = 5'h08;
  localparam logic [4:0] ADDR_BITS      = 5'h18;
  localparam logic [3:0] DUMMY_FAST     = 4'h8;
  localparam logic [3:0] DUMMY_DUAL_IO  = 4'h4;
  localparam logic [3:0] DUMMY_QUAD_IO  = 4'h6;
  localparam logic [3:0] DUMMY_WORD_QIO = 4'h4;
  localparam logic [3:0] DUMMY_OCTW_QIO = 4'h2;
  localparam int CLK_MHZ          = 100;
  localparam int SW_RESET_US      = 30;
  localparam int SW_RESET_CYCLES  = SW_RESET_US * CLK_MHZ;
  localparam int SCLK_HALF_CYCLES = 8;

  // ----------------------------------------------------------------
  // Controller registers
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_ADDR   = 8'h04;
  localparam logic [7:0] REG_TX     = 8'h08;
  localparam logic [7:0] REG_RX     = 8'h0C;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam logic [7:0] REG_PINS   = 8'h14;
  localparam int CTRL_FOUR_LINE_BIT = 8;
  localparam int CTRL_ADDR_BIT  = 9;
  localparam int CTRL_ALANE_LSB = 10;
  localparam int CTRL_DUMMY_LSB = 12;
  localparam int CTRL_DLANE_LSB = 16;
  localparam int CTRL_READ_BIT  = 18;
  localparam int CTRL_COUNT_LSB = 19;
  localparam logic [3:0] PINS_RESET = 4'h7;

  // Per-opcode phase layout
  typedef struct packed {
    logic       quad;
    logic       read;
    logic       hasAddr;
    logic [2:0] aLanes;
    logic [3:0] dummy;
    logic [2:0] dLanes;
  } op_cfg_t;

endpackage

// [hdl/flash_link_if.sv]
`timescale 1ns/100ps
interface flash_link_if;
  logic       sclk;
  logic       csN;
  logic       rstPinN;
  logic [3:0] hostOut;
  logic [3:0] hostOeN;
  logic [3:0] devOut;
  logic [3:0] devOeN;
  logic [3:0] io;

  // Wire level: host, else device, else pull-up
  assign io = (~hostOeN & hostOut) | (hostOeN & ~devOeN & devOut)
            | (hostOeN & devOeN);

  modport device (input sclk, csN, rstPinN, io, output devOut, devOeN);
  modport host (output sclk, csN, rstPinN, hostOut, hostOeN, input io);
endinterface

// [hdl/flash_device_end.sv]
// Decided for this implementation: register access over APB and the address map.
`timescale 1ns/100ps
// Behaviour
// - Chip select high: deselected, all lines floating
// - Frame starts only after chip select falls
// - Single line: sample rising, shift out falling
// - Dual/quad: inputs rising, outputs change falling
// - Quad commands need quad enable; pins become IO2/IO3
// - Active-low write-protect blocks status writes
// - Pause floats output, ignores clock and input
// - Protect/pause/reset pins only outside quad use
// - Small package: setting picks pause or reset
// - Large package: dedicated reset ignores quad enable
// - Clock modes 0 and 3 both accepted
// - Dual reads use IO0 and IO1
// - Quad reads use IO0 to IO3
// - Opcode 38h enters, FFh leaves four-line mode
// - Opcode: eight clocks single, two clocks four-line
// - Reset returns to single-line mode
// - Four-line entry only with quad enable set
// - Pause starts/ends only while clock low
// - 66h then 99h resets; busy 30us
module flash_device_end #(
  parameter int RESET_CYCLES = flash_port_pkg::SW_RESET_CYCLES
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Flash pins
  flash_link_if.device     link,
  // Nonvolatile configuration
  input  wire logic        quadEnable,
  input  wire logic        holdIsReset,
  input  wire logic        bigPackage,
  input  wire logic [1:0]  guardBits,
  input  wire logic [2:0]  blockProtect,
  // Command stream
  output logic      [7:0]  opcode,
  output logic             opcodeValid,
  output logic      [23:0] address,
  output logic             addrValid,
  output logic      [7:0]  rxByte,
  output logic             rxValid,
  input  wire logic [7:0]  txByte,
  output logic             txReq,
  // Status
  output logic             fourLineMode,
  output logic             paused,
  output logic             resetBusy,
  output logic             statusWriteBlocked,
  output logic             areaProtected
);

  localparam int RCW = $clog2(RESET_CYCLES + 1);

  typedef enum {S_WAIT, S_OPC, S_ADDR, S_DUMMY, S_DOUT, S_DIN, S_IGNORE,
                S_RESET} state_t;

  state_t                  state;
  flash_port_pkg::op_cfg_t cfg;
  logic [1:0]              sclkS;
  logic [1:0]              csS;
  logic [1:0]              rstS;
  logic [3:0]              ioA;
  logic [3:0]              ioB;
  logic                    sclkPrev;
  logic                    sawHigh;
  logic                    armed;
  logic [4:0]              cnt;
  logic [2:0]              lanes;
  logic [23:0]             sh;
  logic [7:0]              outSh;
  logic [3:0]              outCnt;
  logic [3:0]              oeHold;
  logic [RCW-1:0]          rcnt;
  logic                    rise;
  logic                    fall;
  logic                    csHigh;
  logic                    holdOn;
  logic                    pinReset;
  logic                    kill;
  logic [4:0]              cntNext;
  logic [23:0]             shNext;
  flash_port_pkg::op_cfg_t opNew;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [23:0] shiftIn(logic [23:0] s, logic [3:0] d,
                                          logic [2:0] l);
    case (l)
      3'h1:    shiftIn = {s[22:0], d[0]};
      3'h2:    shiftIn = {s[21:0], d[1:0]};
      default: shiftIn = {s[19:0], d};
    endcase
  endfunction

  function automatic logic [7:0] drive(logic [3:0] top, logic [2:0] l);
    case (l)
      3'h1:    drive = {4'hD, 2'b00, top[3], 1'b0};
      3'h2:    drive = {4'hC, 2'b00, top[3:2]};
      default: drive = {4'h0, top};
    endcase
  endfunction

  function automatic flash_port_pkg::op_cfg_t opCfg(logic [7:0] op,
                                                    logic four_line_command_mode);
    flash_port_pkg::op_cfg_t c;
    c = '{1'b0, 1'b0, 1'b0, 3'h1, 4'h0, 3'h1};
    case (op)
      flash_port_pkg::OP_READ:
        c = '{1'b0, 1'b1, 1'b1, 3'h1, 4'h0, 3'h1};
      flash_port_pkg::OP_FAST:
        c = '{1'b0, 1'b1, 1'b1, 3'h1, flash_port_pkg::DUMMY_FAST, 3'h1};
      flash_port_pkg::OP_DUAL_OUT:
        c = '{1'b0, 1'b1, 1'b1, 3'h1, flash_port_pkg::DUMMY_FAST, 3'h2};
      flash_port_pkg::OP_DUAL_IO:
        c = '{1'b0, 1'b1, 1'b1, 3'h2, flash_port_pkg::DUMMY_DUAL_IO, 3'h2};
      flash_port_pkg::OP_QUAD_OUT:
        c = '{1'b1, 1'b1, 1'b1, 3'h1, flash_port_pkg::DUMMY_FAST, 3'h4};
      flash_port_pkg::OP_QUAD_IO:
        c = '{1'b1, 1'b1, 1'b1, 3'h4, flash_port_pkg::DUMMY_QUAD_IO, 3'h4};
      flash_port_pkg::OP_WORD_QIO:
        c = '{1'b1, 1'b1, 1'b1, 3'h4, flash_port_pkg::DUMMY_WORD_QIO, 3'h4};
      flash_port_pkg::OP_OCTW_QIO:
        c = '{1'b1, 1'b1, 1'b1, 3'h4, flash_port_pkg::DUMMY_OCTW_QIO, 3'h4};
      flash_port_pkg::OP_STAT1, flash_port_pkg::OP_STAT2,
      flash_port_pkg::OP_STAT3:
        c = '{1'b0, 1'b1, 1'b0, 3'h1, 4'h0, 3'h1};
      default: ;
    endcase
    if (four_line_command_mode) begin
      c.aLanes = 3'h4;
      c.dLanes = 3'h4;
    end
    return c;
  endfunction

  // ----------------------------------------------------------------
  // Pin synchronisers and edges
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      sclkS    <= 2'b00;
      csS      <= 2'b11;
      rstS     <= 2'b11;
      ioA      <= 4'hF;
      ioB      <= 4'hF;
      sclkPrev <= 1'b0;
    end else begin
      sclkS    <= {sclkS[0], link.sclk};
      csS      <= {csS[0], link.csN};
      rstS     <= {rstS[0], link.rstPinN};
      ioA      <= link.io;
      ioB      <= ioA;
      sclkPrev <= sclkS[1];
    end
  end

  // Both clock idle levels work: only edges inside a frame count
  assign rise     = sclkS[1] & ~sclkPrev;
  assign fall     = ~sclkS[1] & sclkPrev;
  assign csHigh   = csS[1];
  assign holdOn   = ~quadEnable & (bigPackage | ~holdIsReset);
  assign pinReset = bigPackage ? ~rstS[1]
                  : (~quadEnable & holdIsReset & ~ioB[3]);
  assign kill     = rst | pinReset;
  assign cntNext  = cnt + {2'b00, lanes};
  assign shNext   = shiftIn(sh, ioB, lanes);
  assign opNew    = opCfg(shNext[7:0], fourLineMode);

  // ----------------------------------------------------------------
  // Pause and protection
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (kill || csHigh || !holdOn) begin
      paused <= 1'b0;
    end else if (!sclkS[1]) begin
      paused <= ~ioB[3];
    end
  end

  always_ff @(posedge clk) begin
    if (kill) begin
      statusWriteBlocked <= 1'b0;
      areaProtected      <= 1'b0;
    end else begin
      statusWriteBlocked <= ~quadEnable & ~ioB[2] & guardBits[0];
      areaProtected      <= ~quadEnable & ~ioB[2] & guardBits[0]
                          & (|blockProtect);
    end
  end

  // ----------------------------------------------------------------
  // Frame sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    opcodeValid <= 1'b0;
    addrValid   <= 1'b0;
    rxValid     <= 1'b0;
    if (kill) begin
      state        <= S_WAIT;
      sawHigh      <= 1'b0;
      armed        <= 1'b0;
      fourLineMode <= 1'b0;
      cnt          <= 5'h00;
      lanes        <= 3'h1;
      sh           <= 24'h00_0000;
      cfg          <= '0;
      opcode       <= 8'h00;
      address      <= 24'h00_0000;
      rxByte       <= 8'h00;
      rcnt         <= '0;
      resetBusy    <= 1'b0;
    end else if (state == S_RESET) begin
      rcnt <= rcnt - RCW'(1);
      if (rcnt == '0) begin
        state        <= S_WAIT;
        fourLineMode <= 1'b0;
        resetBusy    <= 1'b0;
        sawHigh      <= 1'b0;
      end
    end else if (csHigh) begin
      state   <= S_WAIT;
      sawHigh <= 1'b1;
    end else if (state == S_WAIT) begin
      if (sawHigh) begin
        state   <= S_OPC;
        sawHigh <= 1'b0;
        cnt     <= 5'h00;
        lanes   <= fourLineMode ? 3'h4 : 3'h1;
      end
    end else if (rise && !paused) begin
      case (state)
        S_OPC: begin
          sh  <= shNext;
          cnt <= cntNext;
          if (cntNext == flash_port_pkg::OPC_BITS) begin
            opcode      <= shNext[7:0];
            opcodeValid <= 1'b1;
            cfg         <= opNew;
            cnt         <= 5'h00;
            armed       <= (shNext[7:0] == flash_port_pkg::OP_EN_RESET);
            if (armed && shNext[7:0] == flash_port_pkg::OP_RESET) begin
              state     <= S_RESET;
              resetBusy <= 1'b1;
              rcnt      <= RCW'(RESET_CYCLES - 1);
            end else if (shNext[7:0] == flash_port_pkg::OP_ENTER_4L) begin
              fourLineMode <= fourLineMode | quadEnable;
              state        <= S_IGNORE;
            end else if (shNext[7:0] == flash_port_pkg::OP_EXIT_4L) begin
              fourLineMode <= 1'b0;
              state        <= S_IGNORE;
            end else if (opNew.quad && !quadEnable) begin
              state <= S_IGNORE;
            end else if (opNew.read && opNew.hasAddr) begin
              state <= S_ADDR;
              lanes <= opNew.aLanes;
            end else if (opNew.read) begin
              state <= (opNew.dummy != 4'h0) ? S_DUMMY : S_DOUT;
            end else begin
              state <= S_DIN;
            end
          end
        end
        S_ADDR: begin
          sh  <= shNext;
          cnt <= cntNext;
          if (cntNext == flash_port_pkg::ADDR_BITS) begin
            address   <= shNext;
            addrValid <= 1'b1;
            cnt       <= 5'h00;
            state     <= (cfg.dummy != 4'h0) ? S_DUMMY : S_DOUT;
          end
        end
        S_DUMMY: begin
          cnt <= cnt + 5'h01;
          if (cnt + 5'h01 == {1'b0, cfg.dummy}) begin
            state <= S_DOUT;
          end
        end
        S_DIN: begin
          sh  <= shNext;
          cnt <= cntNext;
          if (cntNext == flash_port_pkg::OPC_BITS) begin
            rxByte  <= shNext[7:0];
            rxValid <= 1'b1;
            cnt     <= 5'h00;
          end
        end
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Read output path
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    txReq <= 1'b0;
    if (kill || csHigh || state != S_DOUT) begin
      link.devOeN <= 4'hF;
      link.devOut <= 4'h0;
      oeHold      <= 4'hF;
      outSh       <= 8'h00;
      outCnt      <= 4'h0;
    end else if (paused) begin
      link.devOeN <= 4'hF;
    end else if (fall) begin
      {oeHold, link.devOut} <= drive(outCnt == 4'h0 ? txByte[7:4]
                                                    : outSh[7:4],
                                     cfg.dLanes);
      link.devOeN <= 4'(drive(4'h0, cfg.dLanes) >> 4);
      outSh       <= (outCnt == 4'h0 ? txByte : outSh) << cfg.dLanes;
      txReq       <= (outCnt == 4'h0);
      outCnt      <= (outCnt + {1'b0, cfg.dLanes} == 4'h8) ? 4'h0
                   : outCnt + {1'b0, cfg.dLanes};
    end else begin
      link.devOeN <= oeHold;
    end
  end

endmodule

// [hdl/flash_host_end.sv]
`timescale 1ns/100ps
module flash_host_end #(
  parameter int HALF = flash_port_pkg::SCLK_HALF_CYCLES
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Flash pins
  flash_link_if.host       link
);

  typedef enum {H_IDLE, H_LEAD, H_RUN, H_TAIL} hstate_t;
  typedef enum {P_OPC, P_ADDR, P_DUMMY, P_DATA, P_DONE} phase_t;

  hstate_t     st;
  phase_t      ph;
  phase_t      np;
  logic [31:0] ctrl;
  logic [23:0] addr;
  logic [31:0] tx;
  logic [31:0] rx;
  logic [3:0]  pins;
  logic [31:0] outSh;
  logic [31:0] rxSh;
  logic [5:0]  left;
  logic [2:0]  lanes;
  logic [7:0]  divCnt;
  logic        tick;
  logic [3:0]  ioA;
  logic [3:0]  ioB;
  logic        acc;
  logic        drvEn;
  logic [2:0]  cnt;

  function automatic logic [2:0] lanesOf(logic [1:0] c);
    case (c)
      2'h0:    lanesOf = 3'h1;
      2'h1:    lanesOf = 3'h2;
      default: lanesOf = 3'h4;
    endcase
  endfunction

  assign cnt = ctrl[flash_port_pkg::CTRL_COUNT_LSB +: 3];
  assign acc = psel & penable & pready;
  assign tick = (divCnt == 8'(HALF - 1));
  assign drvEn = (st == H_LEAD || st == H_RUN)
               && (ph == P_OPC || ph == P_ADDR
                   || (ph == P_DATA && !ctrl[flash_port_pkg::CTRL_READ_BIT]));

  // Phase that follows the current one
  always_comb begin
    if (ph == P_OPC && ctrl[flash_port_pkg::CTRL_ADDR_BIT]) begin
      np = P_ADDR;
    end else if (ph <= P_ADDR
                 && ctrl[flash_port_pkg::CTRL_DUMMY_LSB +: 4] != 4'h0) begin
      np = P_DUMMY;
    end else if (ph <= P_DUMMY && cnt != 3'h0) begin
      np = P_DATA;
    end else begin
      np = P_DONE;
    end
  end

  // ----------------------------------------------------------------
  // APB registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
      addr    <= 24'h00_0000;
      tx      <= 32'h0000_0000;
      pins    <= flash_port_pkg::PINS_RESET;
    end else begin
      pready  <= psel & ~penable & ~pready;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
      if (psel && !penable && !pready) begin
        case (paddr)
          flash_port_pkg::REG_CTRL:   prdata <= ctrl;
          flash_port_pkg::REG_ADDR:   prdata <= {8'h00, addr};
          flash_port_pkg::REG_TX:     prdata <= tx;
          flash_port_pkg::REG_RX:     prdata <= rx;
          flash_port_pkg::REG_STATUS: prdata <= {31'h0, st != H_IDLE};
          flash_port_pkg::REG_PINS:   prdata <= {28'h000_0000, pins};
          default:                    pslverr <= 1'b1;
        endcase
        if (pwrite && paddr == flash_port_pkg::REG_CTRL && st != H_IDLE) begin
          pslverr <= 1'b1;
        end
      end
      if (acc && pwrite && !pslverr) begin
        case (paddr)
          flash_port_pkg::REG_ADDR: addr <= pwdata[23:0];
          flash_port_pkg::REG_TX:   tx   <= pwdata;
          flash_port_pkg::REG_PINS: pins <= pwdata[3:0];
          default: ;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Transfer sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      ioA <= 4'hF;
      ioB <= 4'hF;
    end else begin
      ioA <= link.io;
      ioB <= ioA;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st        <= H_IDLE;
      ph        <= P_OPC;
      ctrl      <= 32'h0000_0000;
      rx        <= 32'h0000_0000;
      outSh     <= 32'h0000_0000;
      rxSh      <= 32'h0000_0000;
      left      <= 6'h00;
      lanes     <= 3'h1;
      divCnt    <= 8'h00;
      link.sclk <= 1'b0;
      link.csN  <= 1'b1;
    end else begin
      divCnt <= (st == H_IDLE || tick) ? 8'h00 : divCnt + 8'h01;
      case (st)
        H_IDLE: begin
          if (acc && pwrite && !pslverr
              && paddr == flash_port_pkg::REG_CTRL) begin
            ctrl     <= pwdata;
            st       <= H_LEAD;
            ph       <= P_OPC;
            link.csN <= 1'b0;
            left     <= 6'h08;
            lanes    <= pwdata[flash_port_pkg::CTRL_FOUR_LINE_BIT]
                        ? 3'h4 : 3'h1;
            outSh    <= {pwdata[7:0], 24'h00_0000};
            rxSh     <= 32'h0000_0000;
          end
        end
        H_LEAD: begin
          if (tick) begin
            st <= H_RUN;
          end
        end
        H_RUN: begin
          if (tick && !link.sclk) begin
            link.sclk <= 1'b1;
            left      <= left - ((ph == P_DUMMY) ? 6'h01 : {3'h0, lanes});
            if (ph == P_DATA) begin
              case (lanes)
                3'h1:    rxSh <= {rxSh[30:0], ioB[1]};
                3'h2:    rxSh <= {rxSh[29:0], ioB[1:0]};
                default: rxSh <= {rxSh[27:0], ioB};
              endcase
            end
          end else if (tick) begin
            link.sclk <= 1'b0;
            if (left != 6'h00) begin
              outSh <= outSh << lanes;
            end else begin
              ph <= np;
              case (np)
                P_ADDR: begin
                  left  <= 6'h18;
                  lanes <= lanesOf(ctrl[flash_port_pkg::CTRL_ALANE_LSB +: 2]);
                  outSh <= {addr, 8'h00};
                end
                P_DUMMY: begin
                  left <= {2'h0, ctrl[flash_port_pkg::CTRL_DUMMY_LSB +: 4]};
                end
                P_DATA: begin
                  left  <= {cnt, 3'h0};
                  lanes <= lanesOf(ctrl[flash_port_pkg::CTRL_DLANE_LSB +: 2]);
                  outSh <= tx << {(3'h4 - cnt), 3'h0};
                end
                default: st <= H_TAIL;
              endcase
            end
          end
        end
        H_TAIL: begin
          if (tick) begin
            link.csN <= 1'b1;
            rx       <= rxSh;
            st       <= H_IDLE;
          end
        end
        default: st <= H_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Pin drivers
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      link.hostOut <= 4'h0;
      link.hostOeN <= 4'hF;
      link.rstPinN <= 1'b1;
    end else begin
      link.rstPinN <= pins[2];
      link.hostOut <= {pins[1], pins[0], 2'b00};
      link.hostOeN <= pins[3] ? 4'h3 : 4'hF;
      if (drvEn) begin
        case (lanes)
          3'h1: begin
            link.hostOut[0] <= outSh[31];
            link.hostOeN[0] <= 1'b0;
          end
          3'h2: begin
            link.hostOut[1:0] <= outSh[31:30];
            link.hostOeN[1:0] <= 2'b00;
          end
          default: begin
            link.hostOut <= outSh[31:28];
            link.hostOeN <= 4'h0;
          end
        endcase
      end else if (lanes == 3'h4 && st != H_IDLE) begin
        link.hostOeN <= 4'hF;
      end
    end
  end

endmodule

// [bench/flash_link_monitor.sv]
`timescale 1ns/100ps
module flash_link_monitor (
  // Bench clock
  input wire logic       clk,
  input wire logic       rst,
  // Link
  input wire logic       sclk,
  input wire logic       csN,
  input wire logic [3:0] hostOut,
  input wire logic [3:0] hostOeN,
  input wire logic [3:0] devOut,
  input wire logic [3:0] devOeN
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_idle; csN [*6]; endsequence
  sequence s_move(x); !csN && $changed(x); endsequence
  property p_idle; s_idle |-> &devOeN; endproperty
  a_idle: assert property (p_idle) else $error("idle drive");
  property p_clash; (~devOeN & ~hostOeN) == 4'h0; endproperty
  a_clash: assert property (p_clash) else $error("clash");
  property p_devOut; s_move(devOut & ~devOeN) |-> !sclk; endproperty
  a_devOut: assert property (p_devOut) else $error("dev out");
  property p_devEn; s_move(devOeN) |-> !sclk; endproperty
  a_devEn: assert property (p_devEn) else $error("dev en");
  property p_hostOut; s_move(hostOut[1:0]) |-> !sclk; endproperty
  a_hostOut: assert property (p_hostOut) else $error("host out");
  property p_csFall; $fell(csN) |-> !sclk; endproperty
  a_csFall: assert property (p_csFall) else $error("cs fall");
  property p_csRise; $rose(csN) |-> !sclk; endproperty
  a_csRise: assert property (p_csRise) else $error("cs rise");
  property p_clkSel; $changed(sclk) |-> !csN; endproperty
  a_clkSel: assert property (p_clkSel) else $error("clk idle");
endmodule

// [bench/tb_quad_serial_flash_bus_port.sv]
`timescale 1ns/100ps
module tb_quad_serial_flash_bus_port;
  logic        clk, rst, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0]  paddr, opcode, txByte, gotOp, sent[$];
  logic [31:0] pwdata, prdata, rd, seed;
  logic [23:0] address, gotA, adr;
  logic        quadEnable, holdIsReset, bigPackage, opcodeValid, addrValid;
  logic        txReq, fourLineMode, paused, resetBusy;
  logic        statusWriteBlocked, areaProtected;
  logic [1:0]  guardBits;
  logic [2:0]  blockProtect;
  int          errors, totalChecks;
  logic [15:0] rt [8] = '{16'h0300, 16'h3B21, 16'hBB51, 16'h6B22,
                          16'hEB9A, 16'hE792, 16'hE38A, 16'h0B20};
  flash_link_if link();
  flash_host_end i_flash_host_end (.clk, .rst, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .link);
  flash_device_end #(.RESET_CYCLES(200)) i_flash_device_end (.clk, .rst,
    .link, .quadEnable, .holdIsReset, .bigPackage, .guardBits,
    .blockProtect, .opcode, .opcodeValid, .address, .addrValid, .rxByte(),
    .rxValid(), .txByte, .txReq, .fourLineMode, .paused, .resetBusy,
    .statusWriteBlocked, .areaProtected);
  flash_link_monitor i_mon (.clk, .rst, .sclk(link.sclk), .csN(link.csN),
    .hostOut(link.hostOut), .hostOeN(link.hostOeN), .devOut(link.devOut),
    .devOeN(link.devOeN));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  always @(posedge clk) begin
    if (opcodeValid) gotOp <= opcode;
    if (addrValid) gotA <= address;
    if (txReq) begin
      sent.push_back(txByte);
      txByte <= 8'(rnd());
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    totalChecks++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic start(input logic [31:0] c);
    sent.delete();
    adr = 24'(rnd());
    apb(1'b1, 8'h04, {8'h00, adr});
    apb(1'b1, 8'h00, c);
  endtask
  task automatic frame(input logic [31:0] c);
    start(c);
    do apb(1'b0, 8'h10, 32'h0000_0000); while (rd[0] !== 1'b0);
    apb(1'b0, 8'h0C, 32'h0000_0000);
  endtask
  task automatic give_verdict();
    $display("checks %0d errors %0d", totalChecks, errors);
    if (errors == 0 && totalChecks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  function automatic logic [31:0] rctl(input logic [15:0] t);
    return {10'h000, 3'h4, 1'b1, t[1:0], t[5:2], t[7:6], 2'b10, t[15:8]};
  endfunction
  initial begin
    #500000;
    errors++;
    give_verdict();
  end
  initial begin
    seed = 32'h0000_004D;
    {psel, penable, pwrite, paddr, pwdata, holdIsReset, bigPackage} = '0;
    {guardBits, blockProtect} = 5'(rnd());
    quadEnable = 1'b1;
    txByte = 8'(rnd());
    rst = 1'b1;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      frame(rctl(rt[i]));
      chk(rd, {sent[0], sent[1], sent[2], sent[3]});
      chk(32'(gotA), 32'(adr));
      chk(32'(gotOp), 32'(rt[i][15:8]));
    end
    quadEnable <= 1'b0;
    frame(rctl(rt[3]));
    chk(rd, 32'hFFFF_FFFF);
    start(rctl(rt[0]));
    apb(1'b1, 8'h14, 32'h0000_000D);
    wait (paused === 1'b1);
    @(posedge clk);
    apb(1'b0, 8'h10, 32'h0000_0000);
    chk(32'(rd[0]), 32'h0000_0001);
    apb(1'b1, 8'h14, 32'h0000_0007);
    do apb(1'b0, 8'h10, 32'h0000_0000); while (rd[0] !== 1'b0);
    frame(32'h0000_0038);
    chk(32'(fourLineMode), 32'h0000_0000);
    apb(1'b1, 8'h14, 32'h0000_000E);
    repeat (4) @(posedge clk);
    chk(32'(statusWriteBlocked), 32'(guardBits[0]));
    chk(32'(areaProtected), 32'(guardBits[0] & |blockProtect));
    apb(1'b1, 8'h14, 32'h0000_0007);
    quadEnable <= 1'b1;
    frame(32'h0000_0038);
    chk(32'(fourLineMode), 32'h0000_0001);
    frame(32'h0000_01FF);
    chk(32'(fourLineMode), 32'h0000_0000);
    frame(32'h0000_0038);
    frame(32'h0000_0166);
    frame(32'h0000_0199);
    chk(32'(gotOp), 32'h0000_0099);
    chk(32'(resetBusy), 32'h0000_0001);
    wait (resetBusy === 1'b0);
    @(posedge clk);
    chk(32'(fourLineMode), 32'h0000_0000);
    bigPackage <= 1'b1;
    frame(32'h0000_0038);
    chk(32'(fourLineMode), 32'h0000_0001);
    apb(1'b1, 8'h14, 32'h0000_0003);
    apb(1'b0, 8'h14, 32'h0000_0000);
    chk(rd, 32'h0000_0003);
    apb(1'b1, 8'h14, 32'h0000_0007);
    chk(32'(fourLineMode), 32'h0000_0000);
    frame(32'h0000_0005);
    chk(32'(opcode), 32'h0000_0005);
    {bigPackage, quadEnable, holdIsReset} <= 3'b001;
    apb(1'b1, 8'h14, 32'h0000_000D);
    apb(1'b1, 8'h14, 32'h0000_0007);
    repeat (2) @(posedge clk);
    chk(32'(opcode), 32'h0000_0000);
    apb(1'b0, 8'h40, 32'h0000_0000);
    chk(32'(err), 32'h0000_0001);
    give_verdict();
  end
endmodule
